/* File: design/mie_pkg.sv */
package mie_pkg;
   localparam int OPC_W         = 16;
   localparam int ADDR_W        = 7;
   localparam int SEG_ADDR_W    = 5;
   localparam int NIB_W         = 4;
   localparam int WR_SEL_W      = 4;
   localparam int MEM_DEPTH     = 128;
   localparam int SEG_DEPTH     = 32;
   localparam int PAGE_LSB_W    = 3;
   // Opcode prefixes, left aligned within the 16-bit word
   localparam logic [8:0] OP_TMR1_HI    = 9'h02b;  // 0 0010 1011
   localparam logic [8:0] OP_PTR_LO     = 9'h130;  // 1 0011 0000
   localparam logic [8:0] OP_PTR_HI     = 9'h131;  // 1 0011 0001
   localparam logic [8:0] OP_PAGE_LD    = 9'h0ba;  // 0 1011 101 + r6 (8-bit prefix 8'h5d)
   localparam logic [7:0] OP_PAGE8      = 8'h5d;
   localparam logic [8:0] OP_CARRY_MV   = 9'h0b2;
   localparam logic [6:0] OP_SEG_LD     = 7'h23;
   localparam logic [4:0] OP_WR_DIRECT  = 5'h1d;
   localparam logic [4:0] OP_WR_IND_LD  = 5'h19;
   localparam logic [4:0] OP_WR_IND_ST  = 5'h1b;
   localparam logic [7:0] PAGE_STRIDE   = 8'h10;
   localparam logic [3:0] NIB_RESET     = 4'h0;
   typedef enum logic [3:0] {
      MIE_NONE, MIE_TMR1_HI, MIE_PTR_LO, MIE_PTR_HI, MIE_SEG_LD, MIE_WR_DIRECT,
      MIE_WR_IND_LD, MIE_WR_IND_ST, MIE_PAGE_LD, MIE_CARRY_MV
   } mie_op_type;
   typedef enum {MIE_FETCH, MIE_SECOND} mie_state_type;
endpackage

/* File: design/mie_dec_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Decoded instruction travelling from decoder to executor
interface mie_dec_if;
   import mie_pkg::*;
   mie_op_type        op;
   logic [6:0]        mem_addr;
   logic [4:0]        seg_addr;
   logic [3:0]        wr_sel;
   modport dec (output op, mem_addr, seg_addr, wr_sel);
   modport exe (input op, mem_addr, seg_addr, wr_sel);
endinterface
`default_nettype wire

/* File: design/mie_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
// Combinational opcode classifier
module mie_decoder
   import mie_pkg::*;
(
   input  wire logic [15:0] opcode_in,
   mie_dec_if.dec           dec
);
   // Field extraction shared by all opcodes, except wr_sel, which the segment load takes from bits 3..0
   assign dec.mem_addr = opcode_in[6:0];
   assign dec.seg_addr = opcode_in[8:4];
   assign dec.wr_sel   = (opcode_in[15:9] == OP_SEG_LD) ? opcode_in[3:0] : opcode_in[10:7];

   // Longest prefixes tested first
   always_comb begin
      if (opcode_in[15:7] == OP_TMR1_HI) begin
         dec.op = MIE_TMR1_HI;
      end else if (opcode_in[15:7] == OP_PTR_LO) begin
         dec.op = MIE_PTR_LO;
      end else if (opcode_in[15:7] == OP_PTR_HI) begin
         dec.op = MIE_PTR_HI;
      end else if (opcode_in[15:7] == OP_CARRY_MV) begin
         dec.op = MIE_CARRY_MV;
      end else if (opcode_in[15:8] == OP_PAGE8) begin
         dec.op = MIE_PAGE_LD;
      end else if (opcode_in[15:9] == OP_SEG_LD) begin
         dec.op = MIE_SEG_LD;
      end else if (opcode_in[15:11] == OP_WR_DIRECT) begin
         dec.op = MIE_WR_DIRECT;
      end else if (opcode_in[15:11] == OP_WR_IND_LD) begin
         dec.op = MIE_WR_IND_LD;
      end else if (opcode_in[15:11] == OP_WR_IND_ST) begin
         dec.op = MIE_WR_IND_ST;
      end else begin
         dec.op = MIE_NONE;
      end
   end
endmodule
`default_nettype wire

/* File: design/mie_exec.sv */
`timescale 1ns/10ps
`default_nettype none
// Executes the data-move group on a private data and segment memory
module mie_exec (
   input  wire logic                 REF_CLK_IN,
   input  wire logic                 RESET_N_IN,
   input  wire logic                 INSTR_VALID_IN,
   input  wire logic [15:0]          OPCODE_IN,
   input  wire logic                 SEG_WE_IN,
   input  wire logic [4:0]           SEG_WADDR_IN,
   input  wire logic [3:0]           SEG_WDATA_IN,
   output logic                      READY_OUT,
   output logic [3:0]                TIMER1_PRESET_HIGH_NIBBLE_OUT,
   output logic [3:0]                LOOKUP_POINTER_LOW_OUT,
   output logic [3:0]                LOOKUP_POINTER_HIGH_OUT,
   output logic [3:0]                PAGE_REG_OUT,
   output logic [3:0]                ACC_OUT,
   output logic                      CARRY_FLAG_OUT,
   output logic                      ZERO_FLAG_OUT,
   output logic [6:0]                MEM_ADDR_OUT,
   output logic [3:0]                MEM_DATA_OUT
);
   import mie_pkg::*;

   mie_dec_if         dif ();
   mie_state_type     state;
   mie_op_type        held_op;
   logic [6:0]        held_ptr;
   logic [3:0]        held_wr;
   logic [3:0]        mem [MEM_DEPTH];
   logic [3:0]        seg [SEG_DEPTH];
   logic              go;
   logic [3:0]        rd_nib;
   logic [6:0]        ind_addr;

   mie_decoder u_dec (
      .opcode_in (OPCODE_IN),
      .dec       (dif)
   );

   // Indirect target: page bits 2..0 select a 16-nibble page
   function automatic logic [6:0] page_addr(input logic [3:0] pg, input logic [3:0] off);
      page_addr = 7'({pg[2:0], 4'h0} + {3'h0, off});
   endfunction

   assign go       = INSTR_VALID_IN && (state == MIE_FETCH);
   assign rd_nib   = mem[dif.mem_addr];
   assign ind_addr = page_addr(PAGE_REG_OUT, held_ptr[3:0]);

   // Two-cycle sequencing for the indirect forms
   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state    <= MIE_FETCH;
         held_op  <= MIE_NONE;
         held_ptr <= 7'h00;
         held_wr  <= 4'h0;
      end else begin
         case (state)
            MIE_FETCH: begin
               if (go && (dif.op == MIE_WR_IND_LD || dif.op == MIE_WR_IND_ST)) begin
                  state    <= MIE_SECOND;
                  held_op  <= dif.op;
                  held_ptr <= {3'h0, rd_nib};
                  held_wr  <= dif.wr_sel;
               end
            end
            default: begin
               state <= MIE_FETCH;
            end
         endcase
      end
   end

   // Ready is low during the second cycle of an indirect move
   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         READY_OUT <= 1'b1;
      end else begin
         READY_OUT <= !(go && (dif.op == MIE_WR_IND_LD || dif.op == MIE_WR_IND_ST));
      end
   end

   // Peripheral preset, pointer and page nibbles
   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         TIMER1_PRESET_HIGH_NIBBLE_OUT <= NIB_RESET;
         LOOKUP_POINTER_LOW_OUT        <= NIB_RESET;
         LOOKUP_POINTER_HIGH_OUT       <= NIB_RESET;
         PAGE_REG_OUT                  <= NIB_RESET;
      end else if (go) begin
         case (dif.op)
            MIE_TMR1_HI: TIMER1_PRESET_HIGH_NIBBLE_OUT <= rd_nib;
            MIE_PTR_LO:  LOOKUP_POINTER_LOW_OUT        <= rd_nib;
            MIE_PTR_HI:  LOOKUP_POINTER_HIGH_OUT       <= rd_nib;
            MIE_PAGE_LD: PAGE_REG_OUT                  <= rd_nib;
            default: ;
         endcase
      end
   end

   // Accumulator and flags; only the carry move touches the zero flag
   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ACC_OUT        <= NIB_RESET;
         CARRY_FLAG_OUT <= 1'b0;
         ZERO_FLAG_OUT  <= 1'b0;
      end else if (go && dif.op == MIE_CARRY_MV) begin
         ACC_OUT       <= {3'h0, CARRY_FLAG_OUT};
         ZERO_FLAG_OUT <= !CARRY_FLAG_OUT;
      end  // other ops keep the flags
   end

   // Segment RAM written by the display side
   always_ff @(posedge REF_CLK_IN) begin
      if (SEG_WE_IN) begin
         seg[SEG_WADDR_IN] <= SEG_WDATA_IN;
      end
   end

   // Data memory, working registers live in the low 16 nibbles
   always_ff @(posedge REF_CLK_IN) begin
      if (go) begin
         case (dif.op)
            MIE_SEG_LD:    mem[{3'h0, dif.wr_sel}] <= seg[dif.seg_addr];
            MIE_WR_DIRECT: mem[{3'h0, dif.wr_sel}] <= rd_nib;
            MIE_CARRY_MV:  mem[dif.mem_addr] <= {3'h0, CARRY_FLAG_OUT};
            default: ;
         endcase
      end else if (state == MIE_SECOND) begin
         if (held_op == MIE_WR_IND_LD) begin
            mem[{3'h0, held_wr}] <= mem[ind_addr];
         end else begin
            mem[ind_addr] <= mem[{3'h0, held_wr}];
         end
      end
   end

   // Observation of the most recent indirect-store or carry-move memory write target
   always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         MEM_ADDR_OUT <= 7'h00;
         MEM_DATA_OUT <= NIB_RESET;
      end else if (state == MIE_SECOND && held_op == MIE_WR_IND_ST) begin
         MEM_ADDR_OUT <= ind_addr;
         MEM_DATA_OUT <= mem[{3'h0, held_wr}];
      end else if (go && dif.op == MIE_CARRY_MV) begin
         MEM_ADDR_OUT <= dif.mem_addr;
         MEM_DATA_OUT <= {3'h0, CARRY_FLAG_OUT};
      end
   end

   property p_tmr1;
      @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (go && dif.op == MIE_TMR1_HI) |=> TIMER1_PRESET_HIGH_NIBBLE_OUT == $past(rd_nib);
   endproperty
   a_tmr1: assert property (p_tmr1) else $error("timer preset not loaded");
   property p_plo;
      @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (go && dif.op == MIE_PTR_LO) |=> LOOKUP_POINTER_LOW_OUT == $past(rd_nib);
   endproperty
   a_plo: assert property (p_plo) else $error("pointer low not loaded");
   property p_phi;
      @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (go && dif.op == MIE_PTR_HI) |=> LOOKUP_POINTER_HIGH_OUT == $past(rd_nib);
   endproperty
   a_phi: assert property (p_phi) else $error("pointer high not loaded");
   property p_page;
      @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (go && dif.op == MIE_PAGE_LD) |=> PAGE_REG_OUT == $past(rd_nib);
   endproperty
   a_page: assert property (p_page) else $error("page not loaded");
   property p_ind;
      @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (go && (dif.op == MIE_WR_IND_LD || dif.op == MIE_WR_IND_ST))
         |=> !READY_OUT && state == MIE_SECOND ##1 READY_OUT;
   endproperty
   a_ind: assert property (p_ind) else $error("indirect move not two cycles");
   property p_st;
      @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (state == MIE_SECOND && held_op == MIE_WR_IND_ST)
         |=> MEM_ADDR_OUT == {$past(PAGE_REG_OUT[2:0]), $past(held_ptr[3:0])};
   endproperty
   a_st: assert property (p_st) else $error("indirect store address wrong");
   property p_cmv;
      @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (go && dif.op == MIE_CARRY_MV)
         |=> ACC_OUT == {3'h0, CARRY_FLAG_OUT} && MEM_DATA_OUT == ACC_OUT;
   endproperty
   a_cmv: assert property (p_cmv) else $error("carry move result wrong");
   property p_zf;
      @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      (go && dif.op == MIE_CARRY_MV) |=> ZERO_FLAG_OUT == (ACC_OUT == 4'h0);
   endproperty
   a_zf: assert property (p_zf) else $error("zero flag wrong");
   property p_keep;
      @(posedge REF_CLK_IN) disable iff (!RESET_N_IN)
      !(go && dif.op == MIE_CARRY_MV) |=> $stable(ZERO_FLAG_OUT) && $stable(CARRY_FLAG_OUT);
   endproperty
   a_keep: assert property (p_keep) else $error("flag changed");
   c_ind_ld: cover property (@(posedge REF_CLK_IN) go && dif.op == MIE_WR_IND_LD);
   c_ind_st: cover property (@(posedge REF_CLK_IN) go && dif.op == MIE_WR_IND_ST);
   c_cmv:    cover property (@(posedge REF_CLK_IN) go && dif.op == MIE_CARRY_MV);
endmodule
`default_nettype wire

/* File: verification/move_instruction_exec_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module move_instruction_exec_tb_top;
   import mie_pkg::*;
   typedef struct {logic [15:0] tgt; logic [15:0] res; int due;} mie_note_type;
   logic         ref_clk = 1'b0;
   logic         reset_n = 1'b0;
   logic         valid = 1'b0;
   logic         seg_we = 1'b0;
   logic [15:0]  opcode = 16'h0000;
   logic [4:0]   seg_waddr = 5'h00;
   logic [3:0]   seg_wdata = 4'h0;
   logic         ready, cf, zf;
   logic [3:0]   tmr, plo, phi, page_o, acc, mdata;
   logic [6:0]   maddr;
   // Reference model of the target registers and both memories
   logic [3:0]   mem [128];
   logic [3:0]   seg [32];
   logic [3:0]   m_tmr = 4'h0, m_plo = 4'h0, m_phi = 4'h0, m_page = 4'h0, m_acc = 4'h0;
   logic [3:0]   m_mdata = 4'h0;
   logic [6:0]   m_maddr = 7'h00;
   logic         m_zf = 1'b0;
   mie_note_type notes [$];
   mie_note_type n;
   mie_op_type   kinds [6] = '{MIE_TMR1_HI, MIE_PTR_LO, MIE_PTR_HI, MIE_PAGE_LD, MIE_WR_DIRECT,
                               MIE_CARRY_MV};
   int           errors = 0, samples_checked = 0, cyc = 0, i;
   logic [31:0]  seed = 32'h5, x;

   mie_exec dut (
      .REF_CLK_IN(ref_clk), .RESET_N_IN(reset_n), .INSTR_VALID_IN(valid), .OPCODE_IN(opcode),
      .SEG_WE_IN(seg_we), .SEG_WADDR_IN(seg_waddr), .SEG_WDATA_IN(seg_wdata), .READY_OUT(ready),
      .TIMER1_PRESET_HIGH_NIBBLE_OUT(tmr), .LOOKUP_POINTER_LOW_OUT(plo),
      .LOOKUP_POINTER_HIGH_OUT(phi), .PAGE_REG_OUT(page_o), .ACC_OUT(acc),
      .CARRY_FLAG_OUT(cf), .ZERO_FLAG_OUT(zf), .MEM_ADDR_OUT(maddr), .MEM_DATA_OUT(mdata));

   // Clock generator
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   // Cycle count used to time each expected result
   always @(posedge ref_clk) cyc <= cyc + 1;

   // Takes the oldest note off the queue when its result is due
   always @(negedge ref_clk) begin
      if (notes.size() > 0 && notes[0].due == cyc) begin
         n = notes.pop_front();
         `CHK({tmr, plo, phi, page_o}, n.tgt)
         `CHK({acc, zf, maddr, mdata}, n.res)
         `CHK(cf, 1'b0)
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Presents one instruction; an indirect one is followed by a refused request
   task automatic exe(input logic [15:0] op, input bit two);
      @(negedge ref_clk);
      valid = 1'b1;
      opcode = op;
      notes.push_back('{{m_tmr, m_plo, m_phi, m_page}, {m_acc, m_zf, m_maddr, m_mdata},
                        cyc + (two ? 2 : 1)});
      if (two) begin
         @(negedge ref_clk);
         `CHK(ready, 1'b0)
         opcode = {OP_TMR1_HI, 7'h00}; // Must be ignored while busy
         @(negedge ref_clk);
         valid = 1'b0; // Drop the refused request before the next rising edge, after the block is ready again
      end
   endtask

   // Updates the model, then issues the instruction
   task automatic step(input mie_op_type k, input logic [6:0] r, input logic [3:0] w);
      logic [6:0]  ia;
      logic [15:0] op;
      bit          two;
      ia = {m_page[2:0], mem[r]};
      two = 1'b0;
      case (k)
         MIE_TMR1_HI: begin m_tmr = mem[r]; op = {OP_TMR1_HI, r}; end
         MIE_PTR_LO: begin m_plo = mem[r]; op = {OP_PTR_LO, r}; end
         MIE_PTR_HI: begin m_phi = mem[r]; op = {OP_PTR_HI, r}; end
         MIE_PAGE_LD: begin m_page = mem[r]; op = {OP_PAGE_LD, r}; end
         MIE_SEG_LD: begin mem[w] = seg[r[4:0]]; op = {OP_SEG_LD, r[4:0], w}; end
         MIE_WR_DIRECT: begin mem[w] = mem[r]; op = {OP_WR_DIRECT, w, r}; end
         MIE_WR_IND_LD: begin mem[w] = mem[ia]; op = {OP_WR_IND_LD, w, r}; two = 1'b1; end
         MIE_WR_IND_ST: begin
            m_maddr = ia;
            m_mdata = mem[w];
            mem[ia] = mem[w];
            op = {OP_WR_IND_ST, w, r};
            two = 1'b1;
         end
         default: begin
            mem[r] = 4'h0;
            m_acc = 4'h0;
            m_zf = 1'b1;
            m_maddr = r;
            m_mdata = 4'h0;
            op = {OP_CARRY_MV, r};
         end
      endcase
      exe(op, two);
   endtask

   // Places a value in a working register through the segment RAM
   task automatic put(input logic [4:0] d, input logic [3:0] v, input logic [3:0] w);
      @(negedge ref_clk);
      valid = 1'b0;
      seg_we = 1'b1;
      seg_waddr = d;
      seg_wdata = v;
      seg[d] = v;
      @(negedge ref_clk);
      seg_we = 1'b0;
      step(MIE_SEG_LD, {2'b00, d}, w);
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk) reset_n = 1'b1;
      for (i = 0; i < 40; i++) begin
         x = xs();
         put(x[4:0], x[8:5], x[12:9]);
         step(kinds[x[15:13] % 3'd6], {3'b000, x[12:9]}, x[19:16]);
      end
      $display("Test direct and segment loads done");
      for (i = 0; i < 24; i++) begin
         x = xs();
         put(x[4:0], x[8:5], 4'h1);
         step(MIE_PAGE_LD, 7'h01, 4'h0);
         put(x[20:16], x[24:21], 4'h2);
         step(MIE_WR_IND_ST, 7'h02, 4'h1);
         step(MIE_WR_IND_LD, 7'h02, 4'h3);
         step(MIE_PTR_HI, 7'h03, 4'h0);
         if (x[25]) step(MIE_CARRY_MV, x[31:25], 4'h0);
      end
      $display("Test indirect moves and carry move done");
      @(negedge ref_clk) valid = 1'b0;
      repeat (4) @(negedge ref_clk);
      if (notes.size() != 0) errors++; // Every expected result must have been seen
      tally_and_finish();
   end

   // Watchdog
   initial begin
      #200000;
      errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
